/* File: shared/sfc_pkg.sv */
// Constants for the synthesizer calibration and frequency control block
package sfc_pkg;
  // Register offsets
  localparam logic [7:0] SFC_BASE_HIGH_OFS  = 8'h00;
  localparam logic [7:0] SFC_BASE_MID_OFS   = 8'h01;
  localparam logic [7:0] SFC_BASE_LOW_OFS   = 8'h02;
  localparam logic [7:0] SFC_CHANNEL_NUMBER_OFS       = 8'h03;
  localparam logic [7:0] SFC_MDM_HIGH_OFS   = 8'h04;
  localparam logic [7:0] SFC_MDM_LOW_OFS    = 8'h05;
  localparam logic [7:0] SFC_SYNTH_CTL_OFS  = 8'h06;
  localparam logic [7:0] SFC_STATE_CFG_OFS  = 8'h07;
  localparam logic [7:0] SFC_CAL_CFG_OFS    = 8'h08;
  localparam logic [7:0] SFC_TEST_OFS       = 8'h09;
  localparam logic [7:0] SFC_PIN_SEL_OFS    = 8'h0a;
  localparam logic [7:0] SFC_CAL_RES_OFS    = 8'h0b;
  localparam logic [7:0] SFC_CMD_OFS        = 8'h0c;
  localparam logic [7:0] SFC_STATUS_OFS     = 8'h0d;
  localparam logic [7:0] SFC_IRQ_STAT_OFS   = 8'h0e;
  localparam logic [7:0] SFC_IRQ_EN_OFS     = 8'h0f;
  localparam logic [7:0] SFC_IRQ_CLR_OFS    = 8'h10;
  // Reset values
  localparam logic [7:0] SFC_CAL_CFG_RST    = 8'h20;
  localparam logic [7:0] SFC_TEST_RST       = 8'h0b;
  localparam logic [7:0] SFC_ZERO_RST       = 8'h00;
  // Field positions
  localparam int SFC_CMD_CAL_BIT   = 0;
  localparam int SFC_CMD_TX_BIT    = 1;
  localparam int SFC_CMD_IDLE_BIT  = 2;
  localparam int SFC_AUTOCAL_LSB   = 4;
  localparam int SFC_CPCAL_LSB     = 4;
  localparam int SFC_IRQ_DONE_BIT  = 0;
  localparam int SFC_IRQ_LOCK_BIT  = 1;
  // Encodings
  localparam logic [7:0] SFC_TEST_09       = 8'h09;
  localparam logic [7:0] SFC_PIN_LOCK      = 8'h0a;
  localparam logic [5:0] SFC_UNLOCK_CODE   = 6'h3f;
  localparam logic [1:0] SFC_AUTO_NEVER    = 2'h0;
  localparam logic [1:0] SFC_AUTO_ON       = 2'h1;
  localparam logic [1:0] SFC_AUTO_OFF      = 2'h2;
  localparam logic [1:0] SFC_AUTO_OFF4     = 2'h3;
  // Short calibration counts, crystal cycles
  localparam logic [14:0] SFC_CAL_SHORT_09 = 15'd3764;
  localparam logic [14:0] SFC_CAL_SHORT_0B = 15'd4073;
  typedef enum logic [1:0] {
    SFC_IDLE = 2'b00,
    SFC_CAL  = 2'b01,
    SFC_TX   = 2'b11
  } sfc_state_e;
endpackage

/* File: rtl/sfc_synth_ctrl.sv */
// Synthesizer frequency words, calibration sequencing and lock reporting
//
// Design decisions made here: the plain strobed port and the address map.
`timescale 1ns/1ps
`default_nettype none
module sfc_synth_ctrl #(
  parameter logic [14:0] CAL_LONG_09 = 15'd18506,
  parameter logic [14:0] CAL_LONG_0B = 15'd18815
) (
  input  wire logic        CORE_CLK,
  input  wire logic        RESET_N,
  input  wire logic [7:0]  REG_ADDR,
  input  wire logic [7:0]  REG_WDATA,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  output logic      [7:0]  REG_RDATA,
  input  wire logic        TX_DONE,
  input  wire logic        PLL_LOCK,
  output logic      [26:0] CARRIER_WORD,
  output logic      [4:0]  IF_WORD,
  output logic             CAL_ACTIVE,
  output logic             SYNTH_ON,
  output logic             GENERAL_OUTPUT_PIN,
  output logic             IRQ,
  output sfc_pkg::sfc_state_e RADIO_STATE
);
  import sfc_pkg::*;

  // Offset in quarter steps of the synthesizer resolution keeps exponent 0 and 1 exact
  function automatic logic [19:0] channel_number_offset(input logic [7:0] channel_number, input logic [7:0] mant,
                                              input logic [1:0] expo);
    logic [16:0] prod;
    prod = 17'(channel_number * ({1'b1, mant}));
    return 20'({3'b000, prod} << expo);
  endfunction

  function automatic logic [14:0] cal_cycles(input logic [7:0] test, input logic [1:0] cp);
    logic t09;
    t09 = (test == SFC_TEST_09);
    if (cp == 2'b00) begin
      return t09 ? SFC_CAL_SHORT_09 : SFC_CAL_SHORT_0B;
    end
    return t09 ? CAL_LONG_09 : CAL_LONG_0B;
  endfunction

  logic [7:0]  base_freq_high_q, base_freq_mid_q, base_freq_low_q, channel_select_reg_q;
  logic [7:0]  modem_config_high_q, modem_config_low_q, synth_control_q, radio_state_config_q;
  logic [7:0]  synth_cal_config_q, cal_test_setting_q, output_pin_select_q, irq_en_q;
  logic [7:0]  base_freq_high_d, base_freq_mid_d, base_freq_low_d, channel_select_reg_d;
  logic [7:0]  modem_config_high_d, modem_config_low_d, synth_control_d, radio_state_config_d;
  logic [7:0]  synth_cal_config_d, cal_test_setting_d, output_pin_select_d, irq_en_d;
  logic [7:0]  rdata_q, rdata_d;
  logic [26:0] carrier_q, carrier_d;
  logic [4:0]  if_q, if_d;
  logic        lock_s1_q, lock_s2_q, lock_prev_q;
  logic        pin_q, pin_d;
  logic        cmd_wr, cal_stb, tx_stb, idle_stb;
  logic [1:0]  auto_cal_select;
  logic [1:0]  charge_pump_cal_enable;
  logic [5:0]  synth_cal_result;

  sfc_state_e  state_q, state_d;
  logic [14:0] cal_cnt_q, cal_cnt_d;
  logic        ret_tx_q, ret_tx_d;
  logic [1:0]  off_cnt_q, off_cnt_d;
  logic [5:0]  cal_val_q, cal_val_d;
  logic        cal_end;
  logic [1:0]  irq_stat_q, irq_stat_d;

  assign auto_cal_select        = radio_state_config_q[SFC_AUTOCAL_LSB +: 2];
  assign charge_pump_cal_enable = synth_cal_config_q[SFC_CPCAL_LSB +: 2];
  assign cmd_wr   = REG_WR && (REG_ADDR == SFC_CMD_OFS);
  assign cal_stb  = cmd_wr && REG_WDATA[SFC_CMD_CAL_BIT];
  assign tx_stb   = cmd_wr && REG_WDATA[SFC_CMD_TX_BIT];
  assign idle_stb = cmd_wr && REG_WDATA[SFC_CMD_IDLE_BIT];
  assign synth_cal_result = lock_s2_q ? cal_val_q : SFC_UNLOCK_CODE;

  // Register file and read port
  always_comb begin
    base_freq_high_d     = base_freq_high_q;
    base_freq_mid_d      = base_freq_mid_q;
    base_freq_low_d      = base_freq_low_q;
    channel_select_reg_d = channel_select_reg_q;
    modem_config_high_d  = modem_config_high_q;
    modem_config_low_d   = modem_config_low_q;
    synth_control_d      = synth_control_q;
    radio_state_config_d = radio_state_config_q;
    synth_cal_config_d   = synth_cal_config_q;
    cal_test_setting_d   = cal_test_setting_q;
    output_pin_select_d  = output_pin_select_q;
    irq_en_d             = irq_en_q;
    rdata_d              = 8'h00;
    if (REG_WR) begin
      if (REG_ADDR == SFC_BASE_HIGH_OFS) begin
        base_freq_high_d = REG_WDATA;
      end else if (REG_ADDR == SFC_BASE_MID_OFS) begin
        base_freq_mid_d = REG_WDATA;
      end else if (REG_ADDR == SFC_BASE_LOW_OFS) begin
        base_freq_low_d = REG_WDATA;
      end else if (REG_ADDR == SFC_CHANNEL_NUMBER_OFS) begin
        channel_select_reg_d = REG_WDATA;
      end else if (REG_ADDR == SFC_MDM_HIGH_OFS) begin
        modem_config_high_d = REG_WDATA;
      end else if (REG_ADDR == SFC_MDM_LOW_OFS) begin
        modem_config_low_d = REG_WDATA;
      end else if (REG_ADDR == SFC_SYNTH_CTL_OFS) begin
        synth_control_d = REG_WDATA;
      end else if (REG_ADDR == SFC_STATE_CFG_OFS) begin
        radio_state_config_d = REG_WDATA;
      end else if (REG_ADDR == SFC_CAL_CFG_OFS) begin
        synth_cal_config_d = REG_WDATA;
      end else if (REG_ADDR == SFC_TEST_OFS) begin
        cal_test_setting_d = REG_WDATA;
      end else if (REG_ADDR == SFC_PIN_SEL_OFS) begin
        output_pin_select_d = REG_WDATA;
      end else if (REG_ADDR == SFC_IRQ_EN_OFS) begin
        irq_en_d = REG_WDATA;
      end
    end
    if (REG_RD) begin
      if (REG_ADDR == SFC_BASE_HIGH_OFS) begin
        rdata_d = base_freq_high_q;
      end else if (REG_ADDR == SFC_BASE_MID_OFS) begin
        rdata_d = base_freq_mid_q;
      end else if (REG_ADDR == SFC_BASE_LOW_OFS) begin
        rdata_d = base_freq_low_q;
      end else if (REG_ADDR == SFC_CHANNEL_NUMBER_OFS) begin
        rdata_d = channel_select_reg_q;
      end else if (REG_ADDR == SFC_MDM_HIGH_OFS) begin
        rdata_d = modem_config_high_q;
      end else if (REG_ADDR == SFC_MDM_LOW_OFS) begin
        rdata_d = modem_config_low_q;
      end else if (REG_ADDR == SFC_SYNTH_CTL_OFS) begin
        rdata_d = synth_control_q;
      end else if (REG_ADDR == SFC_STATE_CFG_OFS) begin
        rdata_d = radio_state_config_q;
      end else if (REG_ADDR == SFC_CAL_CFG_OFS) begin
        rdata_d = synth_cal_config_q;
      end else if (REG_ADDR == SFC_TEST_OFS) begin
        rdata_d = cal_test_setting_q;
      end else if (REG_ADDR == SFC_PIN_SEL_OFS) begin
        rdata_d = output_pin_select_q;
      end else if (REG_ADDR == SFC_CAL_RES_OFS) begin
        rdata_d = {2'b00, synth_cal_result};
      end else if (REG_ADDR == SFC_STATUS_OFS) begin
        rdata_d = {4'h0, lock_s2_q, state_q == SFC_CAL, state_q};
      end else if (REG_ADDR == SFC_IRQ_STAT_OFS) begin
        rdata_d = {6'h00, irq_stat_q};
      end else if (REG_ADDR == SFC_IRQ_EN_OFS) begin
        rdata_d = irq_en_q;
      end
    end
    // Words follow the registers every cycle; the host keeps them still outside idle
    carrier_d = {1'b0, base_freq_high_q, base_freq_mid_q, base_freq_low_q, 2'b00}
              + {7'h00, channel_number_offset(channel_select_reg_q, modem_config_low_q,
                                    modem_config_high_q[1:0])};
    if_d  = synth_control_q[4:0];
    pin_d = (output_pin_select_q[5:0] == SFC_PIN_LOCK[5:0]) && lock_s2_q;
  end

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      base_freq_high_q     <= SFC_ZERO_RST;
      base_freq_mid_q      <= SFC_ZERO_RST;
      base_freq_low_q      <= SFC_ZERO_RST;
      channel_select_reg_q <= SFC_ZERO_RST;
      modem_config_high_q  <= SFC_ZERO_RST;
      modem_config_low_q   <= SFC_ZERO_RST;
      synth_control_q      <= SFC_ZERO_RST;
      radio_state_config_q <= SFC_ZERO_RST;
      synth_cal_config_q   <= SFC_CAL_CFG_RST;
      cal_test_setting_q   <= SFC_TEST_RST;
      output_pin_select_q  <= SFC_ZERO_RST;
      irq_en_q             <= SFC_ZERO_RST;
      rdata_q              <= 8'h00;
      carrier_q            <= 27'h0;
      if_q                 <= 5'h00;
      pin_q                <= 1'b0;
    end else begin
      base_freq_high_q     <= base_freq_high_d;
      base_freq_mid_q      <= base_freq_mid_d;
      base_freq_low_q      <= base_freq_low_d;
      channel_select_reg_q <= channel_select_reg_d;
      modem_config_high_q  <= modem_config_high_d;
      modem_config_low_q   <= modem_config_low_d;
      synth_control_q      <= synth_control_d;
      radio_state_config_q <= radio_state_config_d;
      synth_cal_config_q   <= synth_cal_config_d;
      cal_test_setting_q   <= cal_test_setting_d;
      output_pin_select_q  <= output_pin_select_d;
      irq_en_q             <= irq_en_d;
      rdata_q              <= rdata_d;
      carrier_q            <= carrier_d;
      if_q                 <= if_d;
      pin_q                <= pin_d;
    end
  end

  // Lock detector is analog, so it crosses two flops before use
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      lock_s1_q   <= 1'b0;
      lock_s2_q   <= 1'b0;
      lock_prev_q <= 1'b0;
    end else begin
      lock_s1_q   <= PLL_LOCK;
      lock_s2_q   <= lock_s1_q;
      lock_prev_q <= lock_s2_q;
    end
  end

  // Radio control and calibration sequencing
  always_comb begin
    state_d   = state_q;
    cal_cnt_d = cal_cnt_q;
    ret_tx_d  = ret_tx_q;
    off_cnt_d = off_cnt_q;
    cal_val_d = cal_val_q;
    cal_end   = 1'b0;
    case (state_q)
      SFC_IDLE: begin
        if (cal_stb && !tx_stb && !idle_stb) begin
          state_d   = SFC_CAL;
          ret_tx_d  = 1'b0;
          cal_cnt_d = cal_cycles(cal_test_setting_q, charge_pump_cal_enable);
        end else if (tx_stb && !idle_stb) begin
          if (auto_cal_select == SFC_AUTO_ON) begin
            state_d   = SFC_CAL;
            ret_tx_d  = 1'b1;
            cal_cnt_d = cal_cycles(cal_test_setting_q, charge_pump_cal_enable);
          end else begin
            state_d = SFC_TX;
          end
        end
      end
      SFC_CAL: begin
        // Further calibrate strobes fall through here unanswered
        if (idle_stb) begin
          state_d = SFC_IDLE;
        end else if (cal_cnt_q == 15'd1) begin
          cal_end   = 1'b1;
          state_d   = ret_tx_q ? SFC_TX : SFC_IDLE;
          // Code 0x3f is reserved for the unlocked reading
          cal_val_d = (carrier_q[7:2] == SFC_UNLOCK_CODE) ? 6'h3e : carrier_q[7:2];
        end else begin
          cal_cnt_d = cal_cnt_q - 15'd1;
        end
      end
      SFC_TX: begin
        if (idle_stb) begin
          state_d = SFC_IDLE;
        end else if (TX_DONE) begin
          off_cnt_d = off_cnt_q + 2'd1;
          ret_tx_d  = 1'b0;
          cal_cnt_d = cal_cycles(cal_test_setting_q, charge_pump_cal_enable);
          if (auto_cal_select == SFC_AUTO_OFF ||
              (auto_cal_select == SFC_AUTO_OFF4 && off_cnt_q == 2'd3)) begin
            state_d = SFC_CAL;
          end else begin
            state_d = SFC_IDLE;
          end
        end
      end
      default: state_d = SFC_IDLE;
    endcase
  end

  // Calibration value is only cleared by reset, so it outlives sleep
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_q   <= SFC_IDLE;
      cal_cnt_q <= 15'h0000;
      ret_tx_q  <= 1'b0;
      off_cnt_q <= 2'd0;
      cal_val_q <= SFC_UNLOCK_CODE;
    end else begin
      state_q   <= state_d;
      cal_cnt_q <= cal_cnt_d;
      ret_tx_q  <= ret_tx_d;
      off_cnt_q <= off_cnt_d;
      cal_val_q <= cal_val_d;
    end
  end

  // Interrupts; a new event wins over a clear in the same cycle
  always_comb begin
    irq_stat_d = irq_stat_q;
    if (REG_WR && REG_ADDR == SFC_IRQ_CLR_OFS) begin
      irq_stat_d = irq_stat_q & ~REG_WDATA[1:0];
    end
    if (cal_end) begin
      irq_stat_d[SFC_IRQ_DONE_BIT] = 1'b1;
    end
    if (lock_s2_q && !lock_prev_q) begin
      irq_stat_d[SFC_IRQ_LOCK_BIT] = 1'b1;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      irq_stat_q <= 2'b00;
    end else begin
      irq_stat_q <= irq_stat_d;
    end
  end

  assign REG_RDATA          = rdata_q;
  assign CARRIER_WORD       = carrier_q;
  assign IF_WORD            = if_q;
  assign CAL_ACTIVE         = (state_q == SFC_CAL);
  assign SYNTH_ON           = (state_q != SFC_IDLE);
  assign GENERAL_OUTPUT_PIN = pin_q;
  assign IRQ                = |(irq_stat_q & irq_en_q[1:0]);
  assign RADIO_STATE        = state_q;

  // Checking aids: cycles spent in one calibration and its captured setting
  logic [14:0] busy_len_q;
  logic [7:0]  cap_test_q;
  logic [1:0]  cap_cp_q;
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      busy_len_q <= 15'h0000;
      cap_test_q <= 8'h00;
      cap_cp_q   <= 2'b00;
    end else begin
      busy_len_q <= (state_q == SFC_CAL) ? busy_len_q + 15'd1 : 15'h0000;
      if (state_q != SFC_CAL && state_d == SFC_CAL) begin
        cap_test_q <= cal_test_setting_q;
        cap_cp_q   <= charge_pump_cal_enable;
      end
    end
  end

  default clocking dcb @(posedge CORE_CLK); endclocking
  default disable iff (!RESET_N);

  chk_cp_skip_len: assert property (cal_end && cap_cp_q == 2'b00
    |-> busy_len_q == ((cap_test_q == SFC_TEST_09) ? SFC_CAL_SHORT_09
                                                   : SFC_CAL_SHORT_0B) - 15'd1)
    else $error("short calibration length wrong");
  chk_cal_time_09: assert property (cal_end && cap_test_q == SFC_TEST_09
    && cap_cp_q == 2'b10 |-> busy_len_q == CAL_LONG_09 - 15'd1)
    else $error("calibration length for 0x09 wrong");
  chk_cal_time_0b: assert property (cal_end && cap_test_q != SFC_TEST_09
    && cap_cp_q == 2'b10 |-> busy_len_q == CAL_LONG_0B - 15'd1)
    else $error("calibration length for 0x0b wrong");
  chk_base_word: assert property (channel_select_reg_q == 8'h00
    |=> CARRIER_WORD == {1'b0, $past(base_freq_high_q), $past(base_freq_mid_q),
                         $past(base_freq_low_q), 2'b00})
    else $error("carrier not equal to base word");
  chk_channel_number_step: assert property ({base_freq_high_q, base_freq_mid_q,
    base_freq_low_q} == 24'h0 && channel_select_reg_q == 8'h01
    && modem_config_low_q == 8'h00 && modem_config_high_q[1:0] == 2'd2
    |=> CARRIER_WORD == 27'd1024)
    else $error("channel offset wrong");
  chk_if_word: assert property (##1 IF_WORD == $past(synth_control_q[4:0]))
    else $error("if word does not follow field");
  chk_auto_on_cal: assert property (state_q == SFC_IDLE && tx_stb && !idle_stb && !cal_stb
    && auto_cal_select == SFC_AUTO_ON |=> CAL_ACTIVE ##1 CAL_ACTIVE)
    else $error("no calibration on turn-on");
  chk_manual_cal: assert property (state_q == SFC_IDLE && cal_stb && !tx_stb && !idle_stb
    |=> CAL_ACTIVE && !ret_tx_q)
    else $error("calibrate strobe in idle ignored");
  chk_result_hold: assert property (!cal_end |=> $stable(cal_val_q))
    else $error("calibration value changed outside calibration");
  chk_lock_pin: assert property (output_pin_select_q == 8'h0a && $rose(lock_s2_q)
    |=> $rose(GENERAL_OUTPUT_PIN))
    else $error("lock not shown on pin");
  chk_unlock_code: assert property (REG_RD && REG_ADDR == SFC_CAL_RES_OFS && !lock_s2_q
    |=> REG_RDATA == 8'h3f)
    else $error("unlocked result not 0x3f");
  chk_forced_idle: assert property (state_q == SFC_TX && idle_stb
    |=> state_q == SFC_IDLE ##1 !CAL_ACTIVE)
    else $error("forced idle calibrated");
  chk_busy_ignore: assert property (CAL_ACTIVE && cal_stb && !idle_stb && cal_cnt_q > 15'd1
    |=> CAL_ACTIVE && cal_cnt_q == $past(cal_cnt_q) - 15'd1)
    else $error("calibrate strobe restarted calibration");
endmodule // sfc_synth_ctrl
`default_nettype wire

/* File: verification/sfc_host_model.sv */
// Host microcontroller model driving the register port, one strobe at a time
`timescale 1ns/1ps
`default_nettype none
module sfc_host_model (
  input  wire logic       clk,
  input  wire logic [7:0] rdata,
  output logic      [7:0] addr,
  output logic      [7:0] wdata,
  output logic            wr,
  output logic            rd
);
  initial begin
    addr  = 8'h00;
    wdata = 8'h00;
    wr    = 1'b0;
    rd    = 1'b0;
  end
  // Callers touch frequency registers only while the radio is idle
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
    // Released lines never keep the last value, so a late sampler sees junk
    wdata <= ~d;
    addr  <= ~a;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    addr <= ~a;
    @(negedge clk);
    d = rdata;
  endtask
endmodule // sfc_host_model
`default_nettype wire

/* File: verification/test_sfc_synth_ctrl.sv */
// Self-checking bench for the synthesizer control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin err_count++; \
  $display("ERROR %0t mismatch got %h expected %h", $time, (g), (e)); end end
module test_sfc_synth_ctrl;
  import sfc_pkg::*;
  localparam logic [14:0] LONG09 = 15'd50;
  localparam logic [14:0] LONG0B = 15'd60;
  logic        CORE_CLK, RESET_N, REG_WR, REG_RD, TX_DONE, PLL_LOCK;
  logic [7:0]  REG_ADDR, REG_WDATA, REG_RDATA, v, channel_number, mant;
  logic [26:0] CARRIER_WORD, cw;
  logic [4:0]  IF_WORD, ifw;
  logic        CAL_ACTIVE, SYNTH_ON, GENERAL_OUTPUT_PIN, IRQ;
  sfc_state_e  RADIO_STATE;
  logic [23:0] base;
  logic [1:0]  ex;
  logic        rd_p = 1'b0;
  logic [8:0]  exp_q[$];
  int          err_count = 0;
  int          comparisons = 0;
  int          n, m;
  sfc_synth_ctrl #(.CAL_LONG_09(LONG09), .CAL_LONG_0B(LONG0B)) dut (
    .CORE_CLK(CORE_CLK), .RESET_N(RESET_N), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
    .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .TX_DONE(TX_DONE),
    .PLL_LOCK(PLL_LOCK), .CARRIER_WORD(CARRIER_WORD), .IF_WORD(IF_WORD),
    .CAL_ACTIVE(CAL_ACTIVE), .SYNTH_ON(SYNTH_ON), .GENERAL_OUTPUT_PIN(GENERAL_OUTPUT_PIN),
    .IRQ(IRQ), .RADIO_STATE(RADIO_STATE));
  sfc_host_model host (.clk(CORE_CLK), .rdata(REG_RDATA), .addr(REG_ADDR),
    .wdata(REG_WDATA), .wr(REG_WR), .rd(REG_RD));
  initial begin
    CORE_CLK = 1'b0;
    forever #12.5 CORE_CLK = ~CORE_CLK;
  end
  always @(posedge CORE_CLK) rd_p <= REG_RD;
  // Bit 8 of a note asks only that the byte differ from the unlock code
  always @(negedge CORE_CLK) begin
    if (rd_p && exp_q.size() > 0) begin
      if (exp_q[0][8]) `CHK(REG_RDATA !== 8'h3f, 1'b1)
      else `CHK(REG_RDATA, exp_q[0][7:0])
      void'(exp_q.pop_front());
    end
  end
  task automatic wrap_up();
    // A note never taken off the queue means a read answer went missing
    if (exp_q.size() != 0) err_count++;
    if (err_count == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic rexp(input logic [7:0] a, input logic [8:0] e);
    logic [7:0] d;
    // Note goes in after the previous read's compare edge, so the checker cannot pair it early
    @(posedge CORE_CLK);
    exp_q.push_back(e);
    host.rd_reg(a, d);
  endtask
  task automatic cal_len(output int c);
    c = 0;
    @(negedge CORE_CLK);
    while (CAL_ACTIVE === 1'b1 && c < 20000) begin
      c++;
      @(negedge CORE_CLK);
    end
  endtask
  task automatic tx_done();
    @(posedge CORE_CLK);
    TX_DONE <= 1'b1;
    @(posedge CORE_CLK);
    TX_DONE <= 1'b0;
  endtask
  initial begin
    repeat (40000) @(posedge CORE_CLK);
    err_count++;
    wrap_up();
  end
  initial begin
    RESET_N  = 1'b0;
    TX_DONE  = 1'b0;
    PLL_LOCK = 1'b0;
    void'($urandom(32'h1791));
    repeat (12) @(posedge CORE_CLK);
    RESET_N <= 1'b1;
    rexp(SFC_CAL_CFG_OFS, {1'b0, SFC_CAL_CFG_RST});
    rexp(SFC_TEST_OFS, {1'b0, SFC_TEST_RST});
    rexp(SFC_CAL_RES_OFS, 9'h03f);
    rexp(SFC_STATUS_OFS, 9'h000);
    host.wr_reg(SFC_IRQ_STAT_OFS, 8'hff);
    rexp(SFC_IRQ_STAT_OFS, 9'h000);
    rexp(8'h40, 9'h000);
    for (int i = 0; i < 8; i++) begin
      base = (i == 2) ? 24'h000000 : 24'($urandom());
      channel_number = (i == 2) ? 8'h01 : 8'($urandom());
      mant = (i == 2) ? 8'h00 : 8'($urandom());
      ifw  = 5'($urandom());
      ex   = 2'(i);
      host.wr_reg(SFC_BASE_HIGH_OFS, base[23:16]);
      host.wr_reg(SFC_BASE_MID_OFS, base[15:8]);
      host.wr_reg(SFC_BASE_LOW_OFS, base[7:0]);
      host.wr_reg(SFC_CHANNEL_NUMBER_OFS, channel_number);
      host.wr_reg(SFC_MDM_HIGH_OFS, {6'h00, ex});
      host.wr_reg(SFC_MDM_LOW_OFS, mant);
      host.wr_reg(SFC_SYNTH_CTL_OFS, {3'b000, ifw});
      repeat (3) @(negedge CORE_CLK);
      cw = ({3'b000, base} << 2) + ((27'(channel_number) * (27'd256 + 27'(mant))) << ex);
      `CHK(CARRIER_WORD, cw)
      `CHK(IF_WORD, ifw)
    end
    // A second calibrate strobe lands mid-run each pass and must not restart it
    for (int i = 0; i < 4; i++) begin
      host.wr_reg(SFC_TEST_OFS, i[0] ? SFC_TEST_RST : SFC_TEST_09);
      host.wr_reg(SFC_CAL_CFG_OFS, i[1] ? SFC_CAL_CFG_RST : 8'h00);
      host.wr_reg(SFC_IRQ_EN_OFS, {7'h00, i == 0});
      host.wr_reg(SFC_CMD_OFS, 8'h01);
      fork
        begin
          repeat (10) @(posedge CORE_CLK);
          host.wr_reg(SFC_CMD_OFS, 8'h01);
        end
      join_none
      cal_len(n);
      m = int'(i[1] ? (i[0] ? LONG0B : LONG09) : (i[0] ? SFC_CAL_SHORT_0B : SFC_CAL_SHORT_09));
      `CHK(n, m)
      `CHK(RADIO_STATE, SFC_IDLE)
      @(negedge CORE_CLK);
      `CHK(IRQ, i == 0)
      if (i == 0) rexp(SFC_IRQ_STAT_OFS, 9'h001);
      host.wr_reg(SFC_IRQ_CLR_OFS, 8'h01);
    end
    rexp(SFC_IRQ_STAT_OFS, 9'h000);
    host.wr_reg(SFC_TEST_OFS, SFC_TEST_09);
    host.wr_reg(SFC_CAL_CFG_OFS, SFC_CAL_CFG_RST);
    host.wr_reg(SFC_STATE_CFG_OFS, {2'b00, SFC_AUTO_ON, 4'h0});
    host.wr_reg(SFC_CMD_OFS, 8'h02);
    cal_len(n);
    `CHK(n, int'(LONG09))
    `CHK(RADIO_STATE, SFC_TX)
    `CHK(SYNTH_ON, 1'b1)
    tx_done();
    cal_len(n);
    `CHK(n, 0)
    `CHK(RADIO_STATE, SFC_IDLE)
    // A forced idle must skip calibration, a finished packet must not
    host.wr_reg(SFC_STATE_CFG_OFS, {2'b00, SFC_AUTO_OFF, 4'h0});
    host.wr_reg(SFC_CMD_OFS, 8'h02);
    cal_len(n);
    `CHK(RADIO_STATE, SFC_TX)
    host.wr_reg(SFC_CMD_OFS, 8'h04);
    cal_len(n);
    `CHK(n, 0)
    host.wr_reg(SFC_CMD_OFS, 8'h02);
    tx_done();
    cal_len(n);
    `CHK(n, int'(LONG09))
    // Mid-run reset clears the packet counter before the every-fourth test
    @(posedge CORE_CLK);
    RESET_N <= 1'b0;
    repeat (3) @(posedge CORE_CLK);
    RESET_N <= 1'b1;
    host.wr_reg(SFC_TEST_OFS, SFC_TEST_09);
    host.wr_reg(SFC_STATE_CFG_OFS, {2'b00, SFC_AUTO_OFF4, 4'h0});
    for (int j = 0; j < 4; j++) begin
      host.wr_reg(SFC_CMD_OFS, 8'h02);
      tx_done();
      cal_len(n);
      `CHK(n, (j == 3) ? int'(LONG09) : 0)
    end
    host.wr_reg(SFC_STATE_CFG_OFS, 8'h00);
    host.wr_reg(SFC_CMD_OFS, 8'h01);
    repeat (5) @(posedge CORE_CLK);
    host.wr_reg(SFC_CMD_OFS, 8'h04);
    @(negedge CORE_CLK);
    `CHK(RADIO_STATE, SFC_IDLE)
    `CHK(SYNTH_ON, 1'b0)
    host.wr_reg(SFC_IRQ_CLR_OFS, 8'h03);
    host.wr_reg(SFC_PIN_SEL_OFS, SFC_PIN_LOCK);
    PLL_LOCK <= 1'b1;
    repeat (4) @(negedge CORE_CLK);
    `CHK(GENERAL_OUTPUT_PIN, 1'b1)
    rexp(SFC_IRQ_STAT_OFS, 9'h002);
    rexp(SFC_STATUS_OFS, 9'h008);
    // Calibrate again until the result leaves the unlock code, at most three tries
    for (int k = 0; k < 3; k++) begin
      host.rd_reg(SFC_CAL_RES_OFS, v);
      if (v !== 8'h3f) break;
      host.wr_reg(SFC_CMD_OFS, 8'h01);
      cal_len(n);
    end
    rexp(SFC_CAL_RES_OFS, 9'h100);
    host.wr_reg(SFC_PIN_SEL_OFS, 8'h00);
    repeat (3) @(negedge CORE_CLK);
    `CHK(GENERAL_OUTPUT_PIN, 1'b0)
    @(posedge CORE_CLK);
    PLL_LOCK <= 1'b0;
    repeat (4) @(negedge CORE_CLK);
    rexp(SFC_CAL_RES_OFS, 9'h03f);
    // Let the checker take the last answer before the verdict
    repeat (2) @(posedge CORE_CLK);
    wrap_up();
  end
endmodule // test_sfc_synth_ctrl
`default_nettype wire
